// [hw/sensor_spi_pkg.sv]
// shared constants, pin carrier and state types for the sensor serial port
package sensor_spi_pkg;
  localparam int CLK_HZ = 125_000_000;
  localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
  localparam int STARTUP_NS = 20_000;
  localparam int INIT_NS = 10_000;
  localparam int CONV_NS = 100_000;
  localparam int STARTUP_CYCLES = (STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int INIT_CYCLES = (INIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONV_CYCLES = (CONV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMER_W = 24;
  localparam int MEM_DEPTH_DEF = 64;
  localparam int ADDR_W = 16;
  localparam int BYTE_W = 8;
  localparam logic [7:0] INSTR_READ = 8'h03;
  localparam logic [7:0] INSTR_WRITE = 8'h02;
  localparam logic [15:0] STATUS_ADDR = 16'h0000;
  localparam logic [7:0] STATUS_INIT_BEGIN = 8'h80;
  localparam logic [7:0] STATUS_INIT_DONE = 8'h40;
  localparam int START_BIT = 7;
  localparam int DONE_BIT = 6;
  localparam logic [2:0] LAST_BIT = 3'h7;

  // sampled pin group, all from outside the clock domain
  typedef struct packed {
    logic reset_n;
    logic cs_n;
    logic sck;
    logic sdi;
  } pins_t;

  localparam pins_t PINS_IDLE = '{reset_n: 1'b0, cs_n: 1'b1, sck: 1'b0, sdi: 1'b0};

  typedef enum logic [4:0] {
    ST_RESET = 5'b00001,
    ST_STARTUP = 5'b00010,
    ST_INIT = 5'b00100,
    ST_IDLE = 5'b01000,
    ST_CONV = 5'b10000
  } dev_state_t;

  typedef enum logic [5:0] {
    PH_INSTR = 6'b000001,
    PH_ADDR_HI = 6'b000010,
    PH_ADDR_LO = 6'b000100,
    PH_WRITE = 6'b001000,
    PH_READ = 6'b010000,
    PH_IGNORE = 6'b100000
  } phase_t;
endpackage

// [hw/pin_sync3.sv]
// three-stage pin synchroniser; output moves once stages two and three agree
`timescale 1ns/1ps
module pin_sync3 #(
  parameter int WIDTH = 4,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // pins and filtered result
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] stable_out
);
  logic [WIDTH-1:0] s1;
  logic [WIDTH-1:0] s2;
  logic [WIDTH-1:0] s3;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clk_in) begin
        if (rst_in) begin
          s1[i] <= RESET_VAL[i];
          s2[i] <= RESET_VAL[i];
          s3[i] <= RESET_VAL[i];
          stable_out[i] <= RESET_VAL[i];
        end else begin
          s1[i] <= async_in[i];
          s2[i] <= s1[i];
          s3[i] <= s2[i];
          // a one-sample glitch never reaches the output
          if (s2[i] == s3[i]) begin
            stable_out[i] <= s3[i];
          end
        end
      end
    end
  endgenerate
endmodule

// [hw/sensor_spi_host_port.sv]
// serial port, start-up and conversion sequencing of the sensor device
`timescale 1ns/1ps
module sensor_spi_host_port
  import sensor_spi_pkg::*;
#(
  parameter int MEM_DEPTH = sensor_spi_pkg::MEM_DEPTH_DEF,
  parameter int STARTUP_CYC = sensor_spi_pkg::STARTUP_CYCLES,
  parameter int INIT_CYC = sensor_spi_pkg::INIT_CYCLES,
  parameter int CONV_CYC = sensor_spi_pkg::CONV_CYCLES
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // device pins
  input wire logic reset_n_in,
  input wire logic cs_n_in,
  input wire logic sck_in,
  input wire logic sdi_in,
  output logic sdo_out,
  output logic sdo_oe_out,
  output logic busy_done_out
);
  import sensor_spi_pkg::*;

  localparam int IDX_W = $clog2(MEM_DEPTH);

  sensor_spi_pkg::pins_t raw;
  sensor_spi_pkg::pins_t pins;
  logic sck_q;
  logic cs_n_q;
  dev_state_t dev_state;
  phase_t phase;
  logic [TIMER_W-1:0] timer;
  logic [BYTE_W-1:0] status;
  logic [BYTE_W-1:0] mem [MEM_DEPTH];
  logic [2:0] bit_cnt;
  logic [BYTE_W-1:0] shift_in;
  logic [BYTE_W-1:0] tx_byte;
  logic [BYTE_W-1:0] tx_shift;
  logic [ADDR_W-1:0] addr;
  logic is_read;

  assign raw = '{reset_n: reset_n_in, cs_n: cs_n_in, sck: sck_in, sdi: sdi_in};

  pin_sync3 #(
    .WIDTH($bits(pins_t)),
    .RESET_VAL(PINS_IDLE)
  ) u_sync (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .async_in(raw),
    .stable_out(pins)
  );

  // decode of pin events; only the reset pin acts while chip select is high
  wire hold = rst_in | ~pins.reset_n;
  wire selected = ~pins.cs_n & ~cs_n_q;
  wire cs_fall = ~pins.cs_n & cs_n_q;
  wire sck_rise = selected & pins.sck & ~sck_q;
  wire sck_fall = selected & ~pins.sck & sck_q;
  wire byte_done = sck_rise & (bit_cnt == LAST_BIT);
  wire [BYTE_W-1:0] rx_byte = {shift_in[BYTE_W-2:0], pins.sdi};
  wire [ADDR_W-1:0] addr_inc = addr + 16'h0001;
  wire [ADDR_W-1:0] rd_addr = phase == PH_ADDR_LO ? {addr[15:8], rx_byte} : addr_inc;
  wire rd_in_range = rd_addr < ADDR_W'(MEM_DEPTH);
  wire [BYTE_W-1:0] rd_data = rd_addr == STATUS_ADDR ? status :
                              rd_in_range ? mem[rd_addr[IDX_W-1:0]] : '0;
  wire wr_byte = byte_done & (phase == PH_WRITE);
  wire wr_status = wr_byte & (addr == STATUS_ADDR);
  wire wr_mem = wr_byte & (addr != STATUS_ADDR) & (addr < ADDR_W'(MEM_DEPTH));
  // only an idle device accepts a new control byte; busy writes are dropped
  wire conv_start = wr_status & rx_byte[START_BIT] & (dev_state == ST_IDLE);
  wire timer_zero = timer == '0;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sck_q <= 1'b0;
      cs_n_q <= 1'b1;
    end else begin
      sck_q <= pins.sck;
      cs_n_q <= pins.cs_n;
    end
  end

  // device sequencing: reset, start-up, initialisation, idle, conversion
  always_ff @(posedge clk_in) begin
    if (hold) begin
      dev_state <= ST_RESET;
      timer <= '0;
      status <= '0;
    end else begin
      timer <= timer_zero ? timer : timer - 1'b1;
      unique case (dev_state)
        ST_RESET: begin
          dev_state <= ST_STARTUP;
          timer <= TIMER_W'(STARTUP_CYC - 1);
        end
        ST_STARTUP: begin
          if (timer_zero) begin
            dev_state <= ST_INIT;
            timer <= TIMER_W'(INIT_CYC - 1);
            status <= STATUS_INIT_BEGIN;
          end
        end
        ST_INIT: begin
          if (timer_zero) begin
            dev_state <= ST_IDLE;
            status <= STATUS_INIT_DONE;
          end
        end
        ST_IDLE: begin
          if (conv_start) begin
            dev_state <= ST_CONV;
            timer <= TIMER_W'(CONV_CYC - 1);
            status <= rx_byte;
          end else if (wr_status) begin
            status <= rx_byte;
          end
        end
        ST_CONV: begin
          if (timer_zero) begin
            dev_state <= ST_IDLE;
            status <= {1'b0, 1'b1, status[DONE_BIT-1:0]};
          end
        end
      endcase
    end
  end

  // flop-held state, low in every busy state and during reset
  assign busy_done_out = dev_state == ST_IDLE;

  // byte storage, one flop row per entry
  genvar e;
  generate
    for (e = 0; e < MEM_DEPTH; e++) begin : g_mem
      always_ff @(posedge clk_in) begin
        if (hold) begin
          mem[e] <= '0;
        end else if (wr_mem & (addr[IDX_W-1:0] == IDX_W'(e))) begin
          mem[e] <= rx_byte;
        end
      end
    end
  endgenerate

  // receive side and transaction phase
  always_ff @(posedge clk_in) begin
    if (hold | cs_fall) begin
      phase <= PH_INSTR;
      bit_cnt <= '0;
      shift_in <= '0;
      addr <= '0;
      is_read <= 1'b0;
      tx_byte <= '0;
    end else if (sck_rise) begin
      shift_in <= rx_byte;
      bit_cnt <= bit_cnt + 3'h1;
      if (byte_done) begin
        unique case (phase)
          PH_INSTR: begin
            is_read <= rx_byte == INSTR_READ;
            phase <= (rx_byte == INSTR_READ || rx_byte == INSTR_WRITE) ? PH_ADDR_HI
                                                                       : PH_IGNORE;
          end
          PH_ADDR_HI: begin
            addr[15:8] <= rx_byte;
            phase <= PH_ADDR_LO;
          end
          PH_ADDR_LO: begin
            addr[7:0] <= rx_byte;
            phase <= is_read ? PH_READ : PH_WRITE;
            tx_byte <= rd_data;
          end
          PH_READ: begin
            addr <= addr_inc;
            tx_byte <= rd_data;
          end
          PH_WRITE: begin
            addr <= addr_inc;
          end
          PH_IGNORE: begin
            phase <= PH_IGNORE;
          end
        endcase
      end
    end
  end

  // transmit side; a new byte starts on the first fall after a byte boundary
  always_ff @(posedge clk_in) begin
    if (hold | cs_fall) begin
      sdo_out <= 1'b0;
      tx_shift <= '0;
    end else if (sck_fall && phase == PH_READ) begin
      if (bit_cnt == 3'h0) begin
        sdo_out <= tx_byte[BYTE_W-1];
        tx_shift <= {tx_byte[BYTE_W-2:0], 1'b0};
      end else begin
        sdo_out <= tx_shift[BYTE_W-1];
        tx_shift <= {tx_shift[BYTE_W-2:0], 1'b0};
      end
    end
  end

  // driven while the filtered select is low; released four clocks after the select pin rises, once the pin filter passes it
  assign sdo_oe_out = ~pins.cs_n;
endmodule

// [test/sensor_spi_host_port_props.sv]
// assertion checker bound to the sensor serial port
`timescale 1ns/1ps
module spi_port_props #(
  parameter int STARTUP_CYC = 20,
  parameter int INIT_CYC = 10
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // device pins
  input wire logic reset_n_in,
  input wire logic cs_n_in,
  input wire logic sck_in,
  input wire logic sdi_in,
  input wire logic sdo_out,
  input wire logic sdo_oe_out,
  input wire logic busy_done_out
);
  // eight spare cycles cover the pin filter latency and the single reset cycle
  localparam int T_UP = STARTUP_CYC + INIT_CYC + 8;
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  sequence cs_idle; cs_n_in[*6]; endsequence
  sequence cs_sel; !cs_n_in[*6]; endsequence
  sequence pin_up; $rose(reset_n_in) ##1 reset_n_in[*8]; endsequence
  a_oe_off_idle: assert property (cs_idle |-> !sdo_oe_out)
    else $error("sdo enabled while deselected");
  a_oe_on_select: assert property (cs_sel |-> sdo_oe_out)
    else $error("sdo not enabled while selected");
  a_sdo_hold_high: assert property ($rose(sck_in) |=> $stable(sdo_out)[*6])
    else $error("sdo moved while serial clock high");
  // the pin filter plus the state flop take six samples before busy must read low
  a_pin_low_busy: assert property (!reset_n_in[*6] |-> !busy_done_out)
    else $error("busy high while reset pin low");
  a_start_busy: assert property (pin_up |-> !busy_done_out)
    else $error("busy high early in start-up");
  a_start_done: assert property (pin_up |-> ##[1:T_UP] busy_done_out)
    else $error("start-up never completed");
  a_conv_busy: assert property ($fell(busy_done_out) && reset_n_in |=> !busy_done_out[*8])
    else $error("busy low too short");
  a_rst_quiet: assert property (disable iff (1'b0) rst_in |=> !busy_done_out && !sdo_oe_out)
    else $error("outputs active in reset");
endmodule
bind sensor_spi_host_port spi_port_props #(.STARTUP_CYC(STARTUP_CYC), .INIT_CYC(INIT_CYC))
  props (.clk_in(clk_in), .rst_in(rst_in), .reset_n_in(reset_n_in), .cs_n_in(cs_n_in),
  .sck_in(sck_in), .sdi_in(sdi_in), .sdo_out(sdo_out), .sdo_oe_out(sdo_oe_out),
  .busy_done_out(busy_done_out));

// [test/spi_host_model.sv]
// host-side serial bus master model, clock idles low
`timescale 1ns/1ps
module spi_host_model (
  // link pins
  output logic cs_n_out,
  output logic sck_out,
  output logic sdi_out,
  input wire logic sdo_in
);
  initial begin
    cs_n_out = 1'b1;
    sck_out = 1'b0;
    sdi_out = 1'b0;
  end
  task automatic open_frame();
    cs_n_out = 1'b0;
    #100;
  endtask
  // sdi is not held after release, so flip it to expose stale sampling
  task automatic close_frame();
    #100;
    cs_n_out = 1'b1;
    sdi_out = ~sdi_out;
    #200;
  endtask
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sdi_out = tx[i];
      #62.5;
      sck_out = 1'b1;
      rx[i] = sdo_in;
      #62.5;
      sck_out = 1'b0;
    end
  endtask
endmodule

// [test/sensor_spi_host_port_bench.sv]
// self-checking bench for the sensor serial port
`timescale 1ns/1ps
module sensor_spi_host_port_bench;
  import sensor_spi_pkg::*;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic reset_n_in = 1'b0;
  wire cs_n, sck, sdi, sdo, sdo_oe, busy;
  // no pull on the line: a released line shows the inverse, so a late enable is seen
  wire sdo_wire = sdo_oe ? sdo : ~sdo;
  int n_fail = 0;
  int num_checks = 0;
  always #4 clk_in = ~clk_in;
  // long initialisation so that one whole status read fits inside it
  sensor_spi_host_port #(.STARTUP_CYC(20), .INIT_CYC(600), .CONV_CYC(30)) dut (
    .clk_in(clk_in), .rst_in(rst_in), .reset_n_in(reset_n_in), .cs_n_in(cs_n),
    .sck_in(sck), .sdi_in(sdi), .sdo_out(sdo), .sdo_oe_out(sdo_oe), .busy_done_out(busy));
  spi_host_model host (.cs_n_out(cs_n), .sck_out(sck), .sdi_out(sdi), .sdo_in(sdo_wire));
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // busy is looked at just after the edge, once the state flop has settled
  task automatic wait_busy();
    int i;
    for (i = 0; i < 2000 && busy !== 1'b1; i++) begin
      @(posedge clk_in);
      #1;
    end
    if (busy !== 1'b1) begin
      n_fail++;
      $display("[ERR] busy_done expected 1 seen %b", busy);
      end_sim();
    end
  endtask
  task automatic xact(input logic [7:0] ins, input logic [15:0] a, input logic [7:0] d0,
                      input logic [7:0] d1, input int n, output logic [7:0] r0, r1);
    logic [7:0] junk;
    host.open_frame();
    host.xfer(ins, junk);
    host.xfer(a[15:8], junk);
    host.xfer(a[7:0], junk);
    host.xfer(d0, r0);
    if (n > 1) host.xfer(d1, r1);
    host.close_frame();
  endtask
  task automatic t_startup();
    logic [7:0] r0, r1;
    @(posedge clk_in) #1 reset_n_in = 1'b1;
    repeat (12) @(posedge clk_in);
    #1;
    chk("busy start", 8'h00, {7'h00, busy});
    xact(INSTR_READ, STATUS_ADDR, 8'h00, 8'h00, 1, r0, r1);
    chk("status init begin", STATUS_INIT_BEGIN, r0);
    chk("busy init", 8'h00, {7'h00, busy});
    wait_busy();
    xact(INSTR_READ, STATUS_ADDR, 8'h00, 8'h00, 1, r0, r1);
    chk("status init", STATUS_INIT_DONE, r0);
  endtask
  task automatic t_memory();
    logic [7:0] r0, r1;
    xact(INSTR_WRITE, 16'h0005, 8'hA5, 8'h3C, 2, r0, r1);
    xact(INSTR_READ, 16'h0005, 8'h00, 8'h00, 2, r0, r1);
    chk("rd 05", 8'hA5, r0);
    chk("rd 06", 8'h3C, r1);
    xact(INSTR_READ, 16'h0040, 8'h00, 8'h00, 1, r0, r1);
    chk("rd out of range", 8'h00, r0);
  endtask
  task automatic t_deselect();
    logic [7:0] r0, r1;
    host.xfer(INSTR_WRITE, r0);
    host.xfer(8'h00, r0);
    host.xfer(8'h05, r0);
    host.xfer(8'hFF, r0);
    // an unknown instruction must leave the rest of the frame without effect
    xact(8'h01, 16'h0005, 8'hFF, 8'h00, 1, r0, r1);
    chk("sdo unknown instr", 8'h00, r0);
    xact(INSTR_READ, 16'h0005, 8'h00, 8'h00, 1, r0, r1);
    chk("rd after deselected", 8'hA5, r0);
  endtask
  task automatic t_conv();
    logic [7:0] r0, r1;
    host.open_frame();
    host.xfer(INSTR_WRITE, r0);
    host.xfer(8'h00, r0);
    host.xfer(8'h00, r0);
    host.xfer(8'h81, r0);
    chk("busy conv", 8'h00, {7'h00, busy});
    host.close_frame();
    wait_busy();
    xact(INSTR_READ, STATUS_ADDR, 8'h00, 8'h00, 1, r0, r1);
    chk("status done", 8'h41, r0);
  endtask
  task automatic t_pin_reset();
    logic [7:0] r0, r1;
    @(posedge clk_in) #1 reset_n_in = 1'b0;
    repeat (8) @(posedge clk_in);
    #1;
    chk("busy pin low", 8'h00, {7'h00, busy});
    t_startup();
    xact(INSTR_READ, 16'h0005, 8'h00, 8'h00, 1, r0, r1);
    chk("rd cleared", 8'h00, r0);
  endtask
  initial begin
    repeat (4) @(posedge clk_in);
    #1 rst_in = 1'b0;
    t_startup();
    t_memory();
    t_deselect();
    t_conv();
    t_pin_reset();
    end_sim();
  end
endmodule
